// *** rtl/light_sensor_adc_setup_params.svh ***
// Constants for the light sensor converter setup block: offsets, fields, resets, timing.
// Assumes a 250 MHz core clock and a byte-wide register port addressed by printed offset.
//
// Functional notes
// - Proximity gain lengthens LED pulse and integration
// - Gain divides converter clock by two-to-exponent
// - Sequencer never clamps LED or gain settings
// - Misc bit five selects high proximity range
// - Misc bit two: zero raw, one proximity
// - IR selector: 0x00 small, 0x03 large diode
// - Aux selector: temperature 0x65, supply 0x75
// - Visible recovery code sets 1..511 clock wait
// - Recovery clock scales with visible gain exponent
// - Visible gain lengthens visible integration time
`ifndef LIGHT_SENSOR_ADC_SETUP_PARAMS_SVH
`define LIGHT_SENSOR_ADC_SETUP_PARAMS_SVH

// Register offsets, as printed
`define LS_OFS_PROX_GAIN 8'h0B
`define LS_OFS_PROX_MISC 8'h0C
`define LS_OFS_IR_SEL 8'h0E
`define LS_OFS_AUX_SEL 8'h0F
`define LS_OFS_VIS_REC 8'h10
`define LS_OFS_VIS_GAIN 8'h11

// Reset values
`define LS_RST_PROX_GAIN 8'h00
`define LS_RST_PROX_MISC 8'h04
`define LS_RST_IR_SEL 8'h00
`define LS_RST_AUX_SEL 8'h65
`define LS_RST_VIS_REC 8'h70
`define LS_RST_VIS_GAIN 8'h00

// Field positions
`define LS_GAIN_LSB 0
`define LS_GAIN_MSB 2
`define LS_RANGE_BIT 5
`define LS_MODE_BIT 2
`define LS_REC_LSB 4
`define LS_REC_MSB 6

// Input selector codes
`define LS_IR_SMALL 8'h00
`define LS_IR_LARGE 8'h03
`define LS_AUX_TEMP 8'h65
`define LS_AUX_SUPPLY 8'h75

// Timing: converter clock period and core clock period
`define LS_ADC_CLK_NS 50
`define LS_CLK_PERIOD_NS 4
`define LS_ADC_CLK_CYCLES ((`LS_ADC_CLK_NS + `LS_CLK_PERIOD_NS - 1) / `LS_CLK_PERIOD_NS)

`endif

// *** rtl/light_sensor_adc_setup_pkg.sv ***
// Types shared by the light sensor converter setup block.
// Assumes the constants header is included by whoever needs numbers.
package light_sensor_adc_setup_pkg;

   // Kind of conversion the sequencer is asked to run
   typedef enum logic [1:0] {MEAS_PROX, MEAS_VIS, MEAS_IR, MEAS_AUX} measure_type;

   // Sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RECOVER, SEQ_INTEGRATE} seq_state_type;

   // Measurement request from the sequencer's owner
   typedef struct packed {
      logic start;
      measure_type kind;
   } meas_req_type;

   // Steering presented to the converter front end
   typedef struct packed {
      logic [7:0] inputSel;
      logic highRange;
      logic rawMode;
      logic convert;
      logic ledOn;
   } adc_ctrl_type;

endpackage : light_sensor_adc_setup_pkg

// *** rtl/light_sensor_adc_setup.sv ***
// Converter setup registers and the measurement sequencer they steer.
// Assumes a single 250 MHz clock, synchronous inputs and a byte register port
// with read data returned in the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
`include "light_sensor_adc_setup_params.svh"

module light_sensor_adc_setup #(
   parameter int INTEG_CLOCKS = 64, // Converter clocks per integration, before gain
   parameter logic [7:0] VIS_INPUT_CODE = 8'h02, // Visible diode selector code
   parameter logic [7:0] PROX_INPUT_CODE = 8'h03 // Proximity diode selector code
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire light_sensor_adc_setup_pkg::meas_req_type measReq,
   output light_sensor_adc_setup_pkg::adc_ctrl_type adcCtrl,
   output logic busy,
   output logic measDone
);

   // Converter clock divider width
   localparam int ADC_DIV = `LS_ADC_CLK_CYCLES;
   localparam int ADC_CW = $clog2(ADC_DIV);
   localparam int INT_CW = $clog2(INTEG_CLOCKS + 1);
   localparam logic [ADC_CW-1:0] ADC_LAST = ADC_CW'(ADC_DIV - 1);

   // Stored fields only; reserved bits are never held
   logic [2:0] proxGainExp; // Proximity gain exponent
   logic proxHighRange; // High signal range for proximity
   logic proxMeasureSelect; // 1 normal proximity, 0 raw
   logic [7:0] irLightInputSelect; // IR light input selector
   logic [7:0] auxiliaryInputSelect; // Auxiliary input selector
   logic [2:0] visibleRecoveryCode; // Visible recovery code
   logic [2:0] visGainExp; // Visible gain exponent

   // Sequencer state
   light_sensor_adc_setup_pkg::seq_state_type state;
   light_sensor_adc_setup_pkg::measure_type activeKind; // Kind being run
   logic [2:0] activeExp; // Divider exponent of the run
   logic [ADC_CW-1:0] adcCnt; // Core cycles within a converter clock
   logic [6:0] gainCnt; // Converter clocks within a scaled clock
   logic [8:0] recLeft; // Scaled clocks of recovery still to wait
   logic [INT_CW-1:0] intLeft; // Scaled clocks of integration left
   logic adcTick; // Last core cycle of a converter clock
   logic scaledTick; // Last core cycle of a gain-divided clock
   logic accept; // Request taken this cycle

   // Divider mask: two-to-exponent minus one
   function automatic logic [6:0] divMask(input logic [2:0] exp);
      divMask = 7'((8'h01 << exp) - 8'h01);
   endfunction : divMask

   // Recovery converter clocks for a code: 1, then 2^(code+2)-1
   function automatic logic [8:0] recoveryClocks(input logic [2:0] code);
      recoveryClocks = (code == 3'h0) ? 9'h001 : 9'((10'h004 << code) - 10'h001);
   endfunction : recoveryClocks

   // Tick decode shared by recovery and integration
   assign adcTick = (adcCnt == ADC_LAST);
   assign scaledTick = adcTick && (gainCnt == divMask(activeExp));
   assign accept = measReq.start && (state == light_sensor_adc_setup_pkg::SEQ_IDLE);

   // Register writes; only defined fields are stored
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         proxGainExp <= 3'(`LS_RST_PROX_GAIN);
         proxHighRange <= 1'b0;
         proxMeasureSelect <= 1'b1;
         irLightInputSelect <= `LS_RST_IR_SEL;
         auxiliaryInputSelect <= `LS_RST_AUX_SEL;
         visibleRecoveryCode <= 3'h7;
         visGainExp <= 3'(`LS_RST_VIS_GAIN);
      end
      else if (regWrite)
      begin
         unique case (regAddr)
            `LS_OFS_PROX_GAIN:
            begin
               // Any exponent is accepted; no protective clamp
               proxGainExp <= regWrData[`LS_GAIN_MSB:`LS_GAIN_LSB];
            end
            `LS_OFS_PROX_MISC:
            begin
               proxHighRange <= regWrData[`LS_RANGE_BIT];
               proxMeasureSelect <= regWrData[`LS_MODE_BIT];
            end
            `LS_OFS_IR_SEL: irLightInputSelect <= regWrData;
            `LS_OFS_AUX_SEL: auxiliaryInputSelect <= regWrData;
            `LS_OFS_VIS_REC:
            begin
               visibleRecoveryCode <= regWrData[`LS_REC_MSB:`LS_REC_LSB];
            end
            `LS_OFS_VIS_GAIN: visGainExp <= regWrData[`LS_GAIN_MSB:`LS_GAIN_LSB];
            default: ; // Unmapped writes are dropped
         endcase
      end
   end

   // Read port: data only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         regRdData <= 8'h00;
      end
      else if (!regRead)
      begin
         regRdData <= 8'h00;
      end
      else
      begin
         // Reserved positions fill with zero
         unique case (regAddr)
            `LS_OFS_PROX_GAIN: regRdData <= {5'h00, proxGainExp};
            `LS_OFS_PROX_MISC: regRdData <= {2'h0, proxHighRange, 2'h0, proxMeasureSelect, 2'h0};
            `LS_OFS_IR_SEL: regRdData <= irLightInputSelect;
            `LS_OFS_AUX_SEL: regRdData <= auxiliaryInputSelect;
            `LS_OFS_VIS_REC: regRdData <= {1'b0, visibleRecoveryCode, 4'h0};
            `LS_OFS_VIS_GAIN: regRdData <= {5'h00, visGainExp};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // Converter clock divider; restarts with each run so timing is exact
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         adcCnt <= '0;
         gainCnt <= 7'h00;
      end
      else if (accept || state == light_sensor_adc_setup_pkg::SEQ_IDLE)
      begin
         adcCnt <= '0;
         gainCnt <= 7'h00;
      end
      else if (adcTick)
      begin
         adcCnt <= '0;
         // Gain divides the converter clock by two-to-exponent
         gainCnt <= scaledTick ? 7'h00 : 7'(gainCnt + 7'h01);
      end
      else
      begin
         adcCnt <= ADC_CW'(adcCnt + 1'b1);
      end
   end

   // Sequencer: latch settings at start, recover, integrate
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= light_sensor_adc_setup_pkg::SEQ_IDLE;
         activeKind <= light_sensor_adc_setup_pkg::MEAS_PROX;
         activeExp <= 3'h0;
         recLeft <= 9'h000;
         intLeft <= '0;
      end
      else
      begin
         unique case (state)
            light_sensor_adc_setup_pkg::SEQ_IDLE:
            begin
               if (accept)
               begin
                  activeKind <= measReq.kind;
                  intLeft <= INT_CW'(INTEG_CLOCKS);
                  // IR and auxiliary conversions run undivided, straight to integration
                  activeExp <= 3'h0;
                  state <= light_sensor_adc_setup_pkg::SEQ_INTEGRATE;
                  if (measReq.kind == light_sensor_adc_setup_pkg::MEAS_VIS)
                  begin
                     // Recovery and integration both run on the visible gain
                     activeExp <= visGainExp;
                     recLeft <= recoveryClocks(visibleRecoveryCode);
                     state <= light_sensor_adc_setup_pkg::SEQ_RECOVER;
                  end
                  else if (measReq.kind == light_sensor_adc_setup_pkg::MEAS_PROX)
                  begin
                     activeExp <= proxGainExp;
                  end
               end
            end
            light_sensor_adc_setup_pkg::SEQ_RECOVER:
            begin
               if (scaledTick)
               begin
                  recLeft <= 9'(recLeft - 9'h001);
                  if (recLeft == 9'h001)
                  begin
                     state <= light_sensor_adc_setup_pkg::SEQ_INTEGRATE;
                  end
               end
            end
            light_sensor_adc_setup_pkg::SEQ_INTEGRATE:
            begin
               if (scaledTick)
               begin
                  intLeft <= INT_CW'(intLeft - 1'b1);
                  if (intLeft == INT_CW'(1))
                  begin
                     state <= light_sensor_adc_setup_pkg::SEQ_IDLE;
                  end
               end
            end
            default: state <= light_sensor_adc_setup_pkg::SEQ_IDLE; // Illegal code recovers
         endcase
      end
   end

   // Converter steering outputs, registered
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         adcCtrl <= '0;
      end
      else if (accept)
      begin
         // Selector, range and mode are fixed for the whole run
         adcCtrl.highRange <= 1'b0;
         adcCtrl.rawMode <= 1'b0;
         adcCtrl.convert <= (measReq.kind != light_sensor_adc_setup_pkg::MEAS_VIS);
         adcCtrl.ledOn <= 1'b0;
         unique case (measReq.kind)
            light_sensor_adc_setup_pkg::MEAS_PROX:
            begin
               adcCtrl.inputSel <= PROX_INPUT_CODE;
               adcCtrl.highRange <= proxHighRange;
               adcCtrl.rawMode <= !proxMeasureSelect;
               // Raw mode measures the diode with no LED pulse
               adcCtrl.ledOn <= proxMeasureSelect;
            end
            light_sensor_adc_setup_pkg::MEAS_VIS: adcCtrl.inputSel <= VIS_INPUT_CODE;
            light_sensor_adc_setup_pkg::MEAS_IR: adcCtrl.inputSel <= irLightInputSelect;
            light_sensor_adc_setup_pkg::MEAS_AUX: adcCtrl.inputSel <= auxiliaryInputSelect;
         endcase
      end
      else if (state == light_sensor_adc_setup_pkg::SEQ_RECOVER && scaledTick && recLeft == 9'h001)
      begin
         adcCtrl.convert <= 1'b1;
      end
      else if (state == light_sensor_adc_setup_pkg::SEQ_INTEGRATE && scaledTick
               && intLeft == INT_CW'(1))
      begin
         // LED and integration end together on the last scaled clock
         adcCtrl.convert <= 1'b0;
         adcCtrl.ledOn <= 1'b0;
      end
   end

   // Busy level and completion pulse
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy <= 1'b0;
         measDone <= 1'b0;
      end
      else
      begin
         busy <= accept || (busy && !(state == light_sensor_adc_setup_pkg::SEQ_INTEGRATE
                 && scaledTick && intLeft == INT_CW'(1)));
         measDone <= (state == light_sensor_adc_setup_pkg::SEQ_INTEGRATE) && scaledTick
                     && (intLeft == INT_CW'(1));
      end
   end

   // Helper counters read only by the checks below
   int ledCycles;
   int convCycles;
   int recCycles;
   int tickCycles; // Core cycles since the last scaled clock
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ledCycles <= 0;
         convCycles <= 0;
         recCycles <= 0;
         tickCycles <= 0;
      end
      else
      begin
         ledCycles <= adcCtrl.ledOn ? ledCycles + 1 : 0;
         convCycles <= adcCtrl.convert ? convCycles + 1 : 0;
         recCycles <= (state == light_sensor_adc_setup_pkg::SEQ_RECOVER) ? recCycles + 1 : 0;
         // Counted apart from the divider so the period check is not a tautology
         tickCycles <= (scaledTick || !busy) ? 0 : tickCycles + 1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_gain_div;
      scaledTick |-> tickCycles == ADC_DIV * (1 << activeExp) - 1;
   endproperty
   a_gain_div: assert property (p_gain_div) else $error("scaled clock wrong");
   property p_led_width;
      $fell(adcCtrl.ledOn) |-> ledCycles == INTEG_CLOCKS * ADC_DIV * (1 << activeExp);
   endproperty
   a_led_width: assert property (p_led_width) else $error("LED pulse width wrong");
   property p_conv_width;
      $fell(adcCtrl.convert) |-> convCycles == INTEG_CLOCKS * ADC_DIV * (1 << activeExp);
   endproperty
   a_conv_width: assert property (p_conv_width) else $error("integration wrong");
   property p_no_clamp;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_PROX |=>
         activeExp == $past(proxGainExp);
   endproperty
   a_no_clamp: assert property (p_no_clamp) else $error("proximity gain altered");
   property p_range;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_PROX |=>
         adcCtrl.highRange == $past(proxHighRange) && adcCtrl.convert;
   endproperty
   a_range: assert property (p_range) else $error("proximity range not applied");
   property p_mode;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_PROX |=>
         adcCtrl.rawMode == !$past(proxMeasureSelect) && adcCtrl.ledOn == $past(proxMeasureSelect);
   endproperty
   a_mode: assert property (p_mode) else $error("proximity mode not applied");
   property p_ir_sel;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_IR |=>
         adcCtrl.inputSel == $past(irLightInputSelect);
   endproperty
   a_ir_sel: assert property (p_ir_sel) else $error("IR selector not routed");
   property p_aux_sel;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_AUX |=>
         adcCtrl.inputSel == $past(auxiliaryInputSelect);
   endproperty
   a_aux_sel: assert property (p_aux_sel) else $error("aux selector not routed");
   property p_recovery;
      $past(state) == light_sensor_adc_setup_pkg::SEQ_RECOVER
         && state == light_sensor_adc_setup_pkg::SEQ_INTEGRATE |->
         recCycles == int'(recoveryClocks(visibleRecoveryCode)) * ADC_DIV * (1 << activeExp);
   endproperty
   a_recovery: assert property (p_recovery) else $error("recovery wait wrong");
   property p_rec_gain;
      accept && measReq.kind == light_sensor_adc_setup_pkg::MEAS_VIS |=>
         activeExp == $past(visGainExp) && !adcCtrl.convert;
   endproperty
   a_rec_gain: assert property (p_rec_gain) else $error("recovery gain wrong");
   property p_reserved;
      $past(regRead) && $past(regAddr) == `LS_OFS_VIS_REC |->
         regRdData[7] == 1'b0 && regRdData[3:0] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule : light_sensor_adc_setup
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the converter setup block: register port and measurement runs.
// Assumes one 250 MHz clock, active-low async reset and the design's package and header.
`timescale 1ns/1ns
`default_nettype none
`include "light_sensor_adc_setup_params.svh"

module tb_top;
   localparam int INTEG = 2; // Short integration keeps runs brief
   localparam int ADCCYC = `LS_ADC_CLK_CYCLES; // Core cycles per converter clock

   logic clk; // Core clock
   logic rst_b; // Reset, active low
   logic [7:0] regAddr; // Register offset
   logic [7:0] regWrData; // Write data
   logic regWrite; // Write strobe
   logic regRead; // Read strobe
   logic [7:0] regRdData; // Read data
   light_sensor_adc_setup_pkg::meas_req_type measReq; // Start and kind
   light_sensor_adc_setup_pkg::adc_ctrl_type adcCtrl; // Front-end steering
   logic busy; // Run in progress
   logic measDone; // End of run pulse
   int num_errors; // Mismatch count
   int cmp_count; // Comparison count

   light_sensor_adc_setup #(.INTEG_CLOCKS(INTEG)) uut (.clk(clk), .rst_b(rst_b),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .measReq(measReq), .adcCtrl(adcCtrl), .busy(busy),
      .measDone(measDone));

   // Free-running clock
   always #2 clk = ~clk;

   // Closing report, the one exit of the run
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Byte comparison, unknown never matches
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   // Count comparison for run lengths
   task automatic check_n(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_n

   // One-cycle write; strobe drops at the next edge, so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   // One-cycle read; data is taken in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd

   // Recovery length in converter clocks for a three-bit code
   function automatic int rec_clocks(input int code);
      return (code == 0) ? 1 : (1 << (code + 2)) - 1;
   endfunction : rec_clocks

   // Start one run, check steering in the second busy cycle, time the done pulse
   task automatic run(input light_sensor_adc_setup_pkg::measure_type k, input int expN,
                      input logic [7:0] sel, input logic [3:0] flags, input bit poke);
      int n;
      @(posedge clk);
      measReq <= '{start: 1'b1, kind: k};
      @(posedge clk);
      measReq.start <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         // Stray start while busy must be ignored
         measReq.start <= (poke && n == 2);
         #1;
         n++;
         if (n == 1)
         begin
            check8("busy", 8'h01, {7'h00, busy});
            check8("inputSel", sel, adcCtrl.inputSel);
            check8("range raw conv led", {4'h0, flags},
                   {4'h0, adcCtrl.highRange, adcCtrl.rawMode, adcCtrl.convert,
                    adcCtrl.ledOn});
         end
         if (n > 20000)
         begin
            num_errors++;
            $display("MISMATCH run length expected %0d seen timeout", expN);
            give_verdict();
         end
      end
      while (measDone !== 1'b1);
      check_n("run length", expN, n);
      check8("busy at done", 8'h00, {7'h00, busy});
      @(posedge clk);
      #1;
      check8("done width", 8'h00, {7'h00, measDone});
   endtask : run

   // Reset values, reserved bits, unmapped offsets, read data width
   task automatic t_regs;
      logic [7:0] d;
      logic [7:0] ofs[6] = '{8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h11};
      logic [7:0] rstv[6] = '{8'h00, 8'h04, 8'h00, 8'h65, 8'h70, 8'h00};
      logic [7:0] mask[6] = '{8'h07, 8'h24, 8'hFF, 8'hFF, 8'h70, 8'h07};
      for (int i = 0; i < 6; i++)
      begin
         rd(ofs[i], d);
         check8("reset value", rstv[i], d);
      end
      @(posedge clk);
      #1;
      check8("read data after slot", 8'h00, regRdData);
      for (int i = 0; i < 6; i++)
      begin
         wr(ofs[i], 8'hFF);
         rd(ofs[i], d);
         check8("reserved bits", mask[i], d);
         wr(ofs[i], rstv[i]);
      end
      wr(8'h0D, 8'h5A);
      rd(8'h0D, d);
      check8("unmapped read", 8'h00, d);
      $display("Test registers done");
   endtask : t_regs

   // Proximity gain 0..5, stray start, then high range in raw mode
   task automatic t_prox;
      for (int e = 0; e <= 5; e++)
      begin
         wr(8'h0B, 8'(e));
         run(light_sensor_adc_setup_pkg::MEAS_PROX, INTEG * ADCCYC * (1 << e), 8'h03,
             4'b0011, e == 0);
      end
      wr(8'h0C, 8'h20);
      wr(8'h0B, 8'h01);
      run(light_sensor_adc_setup_pkg::MEAS_PROX, INTEG * ADCCYC * 2, 8'h03, 4'b1110,
          1'b0);
      wr(8'h0C, 8'h04);
      $display("Test proximity done");
   endtask : t_prox

   // Infrared and auxiliary selectors; proximity gain left at one must not apply
   task automatic t_mux;
      logic [7:0] codes[2] = '{8'h00, 8'h03};
      run(light_sensor_adc_setup_pkg::MEAS_AUX, INTEG * ADCCYC, 8'h65, 4'b0010,
          1'b0);
      wr(8'h0F, 8'h75);
      run(light_sensor_adc_setup_pkg::MEAS_AUX, INTEG * ADCCYC, 8'h75, 4'b0010,
          1'b0);
      foreach (codes[i])
      begin
         wr(8'h0E, codes[i]);
         run(light_sensor_adc_setup_pkg::MEAS_IR, INTEG * ADCCYC, codes[i], 4'b0010,
             1'b0);
      end
      $display("Test selectors done");
   endtask : t_mux

   // Every recovery code at gain zero, then gain two with the inverted code
   task automatic t_vis;
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h10, 8'(c << 4));
         run(light_sensor_adc_setup_pkg::MEAS_VIS, (rec_clocks(c) + INTEG) * ADCCYC,
             8'h02, 4'b0000, 1'b0);
      end
      wr(8'h11, 8'h02);
      wr(8'h10, 8'h50);
      run(light_sensor_adc_setup_pkg::MEAS_VIS, (rec_clocks(5) + INTEG) * ADCCYC * 4,
          8'h02, 4'b0000, 1'b0);
      $display("Test visible recovery done");
   endtask : t_vis

   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      measReq = '0;
      num_errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      #1;
      check8("outputs in reset", 8'h00, {adcCtrl[3:0], busy, measDone, 2'b00});
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_prox();
      t_mux();
      t_vis();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
